/* File: core/gdm_ctrl.sv */
`timescale 1ns/10ps
module gdm_ctrl (
	input  wire logic             clock,
	input  wire logic             arst_n,
	input  wire gdm_pkg::gdm_bus_s bus_req,
	output logic [7:0]            rd_data,
	input  wire logic             pwm_high_phase,
	input  wire logic             zero_current_cmp,
	input  wire logic             under_cmp,
	input  wire logic             over_cmp,
	output logic                  high_gate_drive,
	output logic                  low_gate_drive,
	output logic                  high_drive_strength_select,
	output logic                  pos_sense_pullup_enable,
	output logic                  neg_sense_pulldown_enable,
	output logic                  setpoint_converter_enable,
	output logic [7:0]            coarse_setpoint_code,
	output logic [4:0]            fine_setpoint_code,
	output logic [7:0]            under_threshold_code,
	output logic [7:0]            over_threshold_code,
	output logic                  under_event_flag,
	output logic                  over_event_flag
);
	import gdm_pkg::*;

	// Every assertion here samples on the core clock, quiet in reset
	default clocking cb_core @(posedge clock);
	endclocking
	default disable iff (!arst_n);

	// Software registers
	gdm_dead_s  dead_q, dead_d;
	logic [7:0] coarse_q, coarse_d;
	logic [7:0] fine_q, fine_d;
	logic [7:0] under_q, under_d;
	logic [7:0] over_q, over_d;
	gdm_pe1_s   pe1_q, pe1_d;
	logic       uflag_q, uflag_d;
	logic       oflag_q, oflag_d;
	logic [7:0] rd_q, rd_d;
	logic [7:0] ref_coarse_q, ref_coarse_d;
	logic [4:0] ref_fine_q, ref_fine_d;

	// Gate-drive sequencer
	gdm_state_e state_q, state_d;
	logic       high_q, high_d;
	logic       low_q, low_d;
	logic       pwm_prev_q;
	logic       cycle_start;
	logic       force_off;
	logic       tmr_load;
	logic [3:0] tmr_value;
	logic       tmr_expired;
	logic [3:0] high_wait;
	logic [3:0] low_wait;
	logic       zc_s, uv_s, ov_s;
	logic       wr_flags;

	// Comparators are asynchronous to the core clock
	gdm_sync3 #(
		.WIDTH(3)
	) u_sync (
		.clock   (clock),
		.arst_n  (arst_n),
		.async_in({zero_current_cmp, under_cmp, over_cmp}),
		.sync_out({zc_s, uv_s, ov_s})
	);

	gdm_dead_timer #(
		.WIDTH(4)
	) u_timer (
		.clock     (clock),
		.arst_n    (arst_n),
		.load      (tmr_load),
		.load_value(tmr_value),
		.expired   (tmr_expired)
	);

	// Register writes, flags and read port
	always_comb begin
		dead_d   = dead_q;
		coarse_d = coarse_q;
		fine_d   = fine_q;
		under_d  = under_q;
		over_d   = over_q;
		pe1_d    = pe1_q;
		rd_d     = 8'h00;
		wr_flags = bus_req.wr && (bus_req.addr == GDM_OFS_FLAGS);
		if (bus_req.wr) begin
			case (bus_req.addr)
				GDM_OFS_DEAD:   dead_d   = bus_req.wdata;
				GDM_OFS_COARSE: coarse_d = bus_req.wdata;
				GDM_OFS_FINE:   fine_d   = bus_req.wdata & GDM_FINE_MASK;
				GDM_OFS_UNDER:  under_d  = bus_req.wdata;
				GDM_OFS_OVER:   over_d   = bus_req.wdata;
				GDM_OFS_PE1:    pe1_d    = bus_req.wdata;
				default:        rd_d     = 8'h00;
			endcase
		end
		if (bus_req.rd) begin
			case (bus_req.addr)
				GDM_OFS_DEAD:   rd_d = dead_q;
				GDM_OFS_COARSE: rd_d = coarse_q;
				GDM_OFS_FINE:   rd_d = fine_q & GDM_FINE_MASK;
				GDM_OFS_UNDER:  rd_d = under_q;
				GDM_OFS_OVER:   rd_d = over_q;
				GDM_OFS_PE1:    rd_d = pe1_q;
				GDM_OFS_FLAGS: begin
					rd_d[GDM_FLAG_UNDER_BIT] = uflag_q;
					rd_d[GDM_FLAG_OVER_BIT]  = oflag_q;
				end
				default:        rd_d = 8'h00;
			endcase
		end
		// Write one to clear; a live condition wins over the clear
		uflag_d = (uflag_q && !(wr_flags && bus_req.wdata[GDM_FLAG_UNDER_BIT]))
			|| uv_s;
		oflag_d = (oflag_q && !(wr_flags && bus_req.wdata[GDM_FLAG_OVER_BIT]))
			|| ov_s;
		// Converter sees codes only while enabled
		if (fine_q[GDM_FINE_EN_BIT]) begin
			ref_coarse_d = coarse_q;
			ref_fine_d   = fine_q[GDM_FINE_CODE_W-1:0];
		end else begin
			ref_coarse_d = 8'h00;
			ref_fine_d   = 5'h00;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			dead_q       <= GDM_RST_DEAD;
			coarse_q     <= GDM_RST_COARSE;
			fine_q       <= GDM_RST_FINE;
			under_q      <= GDM_RST_UNDER;
			over_q       <= GDM_RST_OVER;
			pe1_q        <= GDM_RST_PE1;
			uflag_q      <= 1'b0;
			oflag_q      <= 1'b0;
			rd_q         <= 8'h00;
			ref_coarse_q <= 8'h00;
			ref_fine_q   <= 5'h00;
		end else begin
			dead_q       <= dead_d;
			coarse_q     <= coarse_d;
			fine_q       <= fine_d;
			under_q      <= under_d;
			over_q       <= over_d;
			pe1_q        <= pe1_d;
			uflag_q      <= uflag_d;
			oflag_q      <= oflag_d;
			rd_q         <= rd_d;
			ref_coarse_q <= ref_coarse_d;
			ref_fine_q   <= ref_fine_d;
		end
	end

	// Turn-on waits per side; bypass keeps one cycle against shoot-through
	always_comb begin
		high_wait = pe1_q.high_delay_bypass ? GDM_BYPASS_CYCLES
			: gdm_delay_cycles(GDM_HIGH_BASE_NS,
				dead_q.high_turn_on_delay_code);
		low_wait = pe1_q.low_delay_bypass ? GDM_BYPASS_CYCLES
			: gdm_delay_cycles(GDM_LOW_BASE_NS,
				dead_q.low_turn_on_delay_code);
	end

	// Drive sequencer; fast-off beats every other transition
	always_comb begin
		cycle_start = pwm_high_phase && !pwm_prev_q;
		force_off = (uv_s && pe1_q.under_fast_off_enable)
			|| (ov_s && pe1_q.over_fast_off_enable);
		state_d   = state_q;
		tmr_load  = 1'b0;
		tmr_value = high_wait;
		if (force_off) begin
			state_d = GDM_S_WAIT;
		end else begin
			case (state_q)
				GDM_S_WAIT: begin
					if (cycle_start) begin
						state_d  = GDM_S_HIGH_TURN_ON_DELAY_CODE;
						tmr_load = 1'b1;
					end
				end
				GDM_S_HIGH_TURN_ON_DELAY_CODE: begin
					if (tmr_expired) begin
						state_d = GDM_S_HON;
					end
				end
				GDM_S_HON: begin
					if (!pwm_high_phase) begin
						state_d   = GDM_S_LOW_TURN_ON_DELAY_CODE;
						tmr_load  = 1'b1;
						tmr_value = low_wait;
					end
				end
				GDM_S_LOW_TURN_ON_DELAY_CODE: begin
					if (cycle_start) begin
						state_d  = GDM_S_HIGH_TURN_ON_DELAY_CODE;
						tmr_load = 1'b1;
					end else if (tmr_expired) begin
						state_d = GDM_S_LON;
					end
				end
				GDM_S_LON: begin
					if (cycle_start) begin
						state_d  = GDM_S_HIGH_TURN_ON_DELAY_CODE;
						tmr_load = 1'b1;
					end else if (pe1_q.zero_current_mode_select
						&& zc_s) begin
						state_d = GDM_S_WAIT;
					end
				end
				default: state_d = GDM_S_WAIT;
			endcase
		end
		high_d = (state_d == GDM_S_HON);
		low_d  = (state_d == GDM_S_LON);
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_q    <= GDM_S_WAIT;
			high_q     <= 1'b0;
			low_q      <= 1'b0;
			pwm_prev_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			high_q     <= high_d;
			low_q      <= low_d;
			pwm_prev_q <= pwm_high_phase;
		end
	end

	// Outputs straight from flops
	assign rd_data                    = rd_q;
	assign high_gate_drive            = high_q;
	assign low_gate_drive             = low_q;
	assign high_drive_strength_select = pe1_q.high_drive_strength_select;
	assign pos_sense_pullup_enable    = pe1_q.pos_sense_pullup_enable;
	assign neg_sense_pulldown_enable  = pe1_q.neg_sense_pulldown_enable;
	assign setpoint_converter_enable  = fine_q[GDM_FINE_EN_BIT];
	assign coarse_setpoint_code       = ref_coarse_q;
	assign fine_setpoint_code         = ref_fine_q;
	assign under_threshold_code       = under_q;
	assign over_threshold_code        = over_q;
	assign under_event_flag           = uflag_q;
	assign over_event_flag            = oflag_q;

	// Helper: cycles since the dead-time timer was loaded
	logic [3:0] gap_q;
	logic [3:0] want_q;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			gap_q  <= 4'h0;
			want_q <= 4'h0;
		end else if (tmr_load) begin
			gap_q  <= 4'h1;
			want_q <= tmr_value;
		end else if (gap_q != 4'hF) begin
			gap_q <= gap_q + 4'h1;
		end
	end

	sequence s_lon_quiet;
		state_q == GDM_S_LON && !cycle_start && !force_off;
	endsequence

	sequence s_diode_end;
		s_lon_quiet ##0 pe1_q.zero_current_mode_select && zc_s;
	endsequence

	a_no_shoot_through: assert property (!(high_q && low_q))
		else $error("both gate drives high");
	// Drive rises one edge after the gap count reached the wait
	a_dead_gap_len: assert property ($rose(high_q) |->
		$past(state_q) == GDM_S_HIGH_TURN_ON_DELAY_CODE && $past(gap_q) == want_q)
		else $error("high turn-on delay wrong");
	a_bypass_one: assert property (tmr_load && state_q == GDM_S_HON
		&& pe1_q.low_delay_bypass |-> tmr_value == 4'h1)
		else $error("low bypass not one cycle");
	a_setpoint_gated: assert property (!fine_q[GDM_FINE_EN_BIT] |=>
		coarse_setpoint_code == 8'h00 && fine_setpoint_code == 5'h00)
		else $error("set-point passed while disabled");
	a_fine_gap_zero: assert property (bus_req.rd
		&& bus_req.addr == GDM_OFS_FINE |=> rd_data[6:5] == 2'b00)
		else $error("fine register gap bits not zero");
	a_under_flag: assert property (uv_s |=> under_event_flag ##1
		(under_event_flag || $past(wr_flags)))
		else $error("undervoltage flag not set");
	a_over_sticky: assert property (over_event_flag && !wr_flags
		|=> over_event_flag) else $error("overvoltage flag dropped");
	a_diode_wait: assert property (s_diode_end ##1
		(!pwm_high_phase && !force_off)[*2] |-> !low_q && !high_q)
		else $error("diode wait not both low");
	a_sync_hold: assert property (s_lon_quiet
		##0 !pe1_q.zero_current_mode_select |=> low_q)
		else $error("low drive released early");
	a_under_off: assert property (uv_s && pe1_q.under_fast_off_enable
		|=> !high_q && !low_q) else $error("undervoltage fast-off missed");
	a_over_off: assert property (ov_s && pe1_q.over_fast_off_enable
		|=> !high_q && !low_q) else $error("overvoltage fast-off missed");
	a_sync_latency: assert property ((under_cmp && !uv_s)[*4]
		|=> uv_s) else $error("undervoltage sync latency");
endmodule

/* File: core/gdm_dead_timer.sv */
`timescale 1ns/10ps
module gdm_dead_timer #(
	parameter int unsigned WIDTH = 4
) (
	input  wire logic             clock,
	input  wire logic             arst_n,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_value,
	output logic                  expired
);
	import gdm_pkg::*;

	logic [WIDTH-1:0] cnt_q;
	logic [WIDTH-1:0] cnt_d;

	// Down counter; a fresh load always wins over counting
	always_comb begin
		cnt_d = cnt_q;
		if (load) begin
			cnt_d = load_value;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - WIDTH'(1);
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// Last counted cycle, so the waiting edge lands after value cycles
	assign expired = (cnt_q == WIDTH'(1)) && !load;
endmodule

/* File: core/gdm_sync3.sv */
`timescale 1ns/10ps
module gdm_sync3 #(
	parameter int unsigned WIDTH = 3
) (
	input  wire logic             clock,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	import gdm_pkg::*;

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] stage2_q;
	logic [WIDTH-1:0] stage3_q;
	logic [WIDTH-1:0] out_q;
	logic [WIDTH-1:0] out_d;

	// Accept a change only once stages two and three agree
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			out_d[i] = (stage2_q[i] == stage3_q[i]) ? stage3_q[i] : out_q[i];
		end
	end

	// First stage feeds only the second, never the filter
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			meta_q   <= '0;
			stage2_q <= '0;
			stage3_q <= '0;
			out_q    <= '0;
		end else begin
			meta_q   <= async_in;
			stage2_q <= meta_q;
			stage3_q <= stage2_q;
			out_q    <= out_d;
		end
	end

	assign sync_out = out_q;
endmodule

/* File: inc/gdm_pkg.sv */
package gdm_pkg;

	// Register byte addresses, one aligned slot each
	localparam logic [7:0] GDM_OFS_DEAD   = 8'h00;
	localparam logic [7:0] GDM_OFS_COARSE = 8'h04;
	localparam logic [7:0] GDM_OFS_FINE   = 8'h08;
	localparam logic [7:0] GDM_OFS_UNDER  = 8'h0C;
	localparam logic [7:0] GDM_OFS_OVER   = 8'h10;
	localparam logic [7:0] GDM_OFS_PE1    = 8'h14;
	localparam logic [7:0] GDM_OFS_FLAGS  = 8'h18;

	// Values after reset
	localparam logic [7:0] GDM_RST_DEAD   = 8'h00;
	localparam logic [7:0] GDM_RST_COARSE = 8'h00;
	localparam logic [7:0] GDM_RST_FINE   = 8'h00;
	localparam logic [7:0] GDM_RST_UNDER  = 8'h00;
	localparam logic [7:0] GDM_RST_OVER   = 8'h00;
	localparam logic [7:0] GDM_RST_PE1    = 8'h00;

	// Field positions
	localparam int unsigned GDM_FINE_EN_BIT   = 7;
	localparam int unsigned GDM_FINE_CODE_W   = 5;
	localparam logic [7:0]  GDM_FINE_MASK     = 8'h9F;
	localparam int unsigned GDM_FLAG_UNDER_BIT = 1;
	localparam int unsigned GDM_FLAG_OVER_BIT  = 0;

	// Dead-time timing in ns, the bypass wait in cycles, and the core clock period
	localparam int unsigned GDM_CLK_PERIOD_NS = 8;
	localparam int unsigned GDM_HIGH_BASE_NS  = 11;
	localparam int unsigned GDM_LOW_BASE_NS   = 4;
	localparam int unsigned GDM_DEAD_STEP_NS  = 4;
	localparam logic [3:0]  GDM_BYPASS_CYCLES = 4'h1;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} gdm_bus_s;

	typedef struct packed {
		logic zero_current_mode_select;
		logic high_drive_strength_select;
		logic high_delay_bypass;
		logic low_delay_bypass;
		logic neg_sense_pulldown_enable;
		logic pos_sense_pullup_enable;
		logic under_fast_off_enable;
		logic over_fast_off_enable;
	} gdm_pe1_s;

	typedef struct packed {
		logic [3:0] high_turn_on_delay_code;
		logic [3:0] low_turn_on_delay_code;
	} gdm_dead_s;

	typedef enum logic [4:0] {
		GDM_S_WAIT = 5'b0_0001,
		GDM_S_HIGH_TURN_ON_DELAY_CODE = 5'b0_0010,
		GDM_S_HON  = 5'b0_0100,
		GDM_S_LOW_TURN_ON_DELAY_CODE = 5'b0_1000,
		GDM_S_LON  = 5'b1_0000
	} gdm_state_e;

	// Dead-time code to whole clock cycles, least time rounded up
	function automatic logic [3:0] gdm_delay_cycles(
		input int unsigned base_ns,
		input logic [3:0]  code
	);
		int unsigned ns;
		ns = base_ns + GDM_DEAD_STEP_NS * int'(code);
		return 4'((ns + GDM_CLK_PERIOD_NS - 1) / GDM_CLK_PERIOD_NS);
	endfunction

endpackage

/* File: verification/gdm_ctrl_tb_top.sv */
`timescale 1ns/10ps
`define CHK(got, exp) begin \
	n_tests++; \
	if ((got) !== (exp)) begin \
		num_errors++; \
		$display("mismatch at %0t got %h exp %h", $time, (got), (exp)); \
	end \
end

module gdm_ctrl_tb_top;
	import gdm_pkg::*;
	logic       clock = 1'b0;
	logic       arst_n;
	logic       pwm;
	logic       zc;
	logic       uv;
	logic       ov;
	gdm_bus_s   bus;
	logic [7:0] rdat;
	logic [7:0] cs;
	logic [7:0] us;
	logic [7:0] os;
	logic [4:0] fs;
	logic       hi;
	logic       lo;
	logic       str;
	logic       pu;
	logic       pd;
	logic       en;
	logic       uf;
	logic       of;
	int         num_errors = 0;
	int         n_tests = 0;
	int         cycles = 0;

	gdm_ctrl i_dut (
		.clock                      (clock),
		.arst_n                     (arst_n),
		.bus_req                    (bus),
		.rd_data                    (rdat),
		.pwm_high_phase             (pwm),
		.zero_current_cmp           (zc),
		.under_cmp                  (uv),
		.over_cmp                   (ov),
		.high_gate_drive            (hi),
		.low_gate_drive             (lo),
		.high_drive_strength_select (str),
		.pos_sense_pullup_enable    (pu),
		.neg_sense_pulldown_enable  (pd),
		.setpoint_converter_enable  (en),
		.coarse_setpoint_code       (cs),
		.fine_setpoint_code         (fs),
		.under_threshold_code       (us),
		.over_threshold_code        (os),
		.under_event_flag           (uf),
		.over_event_flag            (of)
	);

	gdm_drv_model i_drv (
		.clock            (clock),
		.arst_n           (arst_n),
		.high_gate_drive  (hi),
		.low_gate_drive   (lo),
		.zero_current_cmp (zc)
	);

	// 125 MHz core clock
	always #4 clock = ~clock;

	task automatic report_and_stop();
		if (num_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Hang guard, the run needs well under a tenth of this
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			report_and_stop();
		end
	end

	// Both switches on would short the supply
	always @(negedge clock) begin
		if (hi === 1'b1 && lo === 1'b1)
			`CHK(lo, 1'b0);
	end

	function automatic int ncyc(input int base, input int code);
		return (base + GDM_DEAD_STEP_NS * code + GDM_CLK_PERIOD_NS - 1)
			/ GDM_CLK_PERIOD_NS;
	endfunction

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		bus.wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		bus.rd <= 1'b0;
		#1;
		`CHK(rdat, exp);
	endtask

	task automatic settle();
		repeat (2) @(posedge clock);
		#1;
	endtask

	// Cycles from a phase edge until that side's drive comes on
	task automatic gap(input logic lvl, output int n);
		@(posedge clock);
		pwm <= lvl;
		n = 0;
		do begin
			@(posedge clock);
			#1;
			n++;
		end while ((lvl ? hi : lo) !== 1'b1 && n < 40);
	endtask

	task automatic cyc2(output int gh, output int gl);
		gap(1'b1, gh);
		repeat (4) @(posedge clock);
		gap(1'b0, gl);
		repeat (4) @(posedge clock);
	endtask

	task automatic phase(input logic lvl, input int len);
		@(posedge clock);
		pwm <= lvl;
		repeat (len) @(posedge clock);
		#1;
	endtask

	task automatic t_regs();
		`CHK({hi, lo, str, pu, pd, en, uf, of}, 8'h00);
		for (int i = 0; i < 8; i++)
			rchk(8'(4 * i), 8'h00);
		wr(GDM_OFS_COARSE, 8'h4B); // 1.2 V set point
		wr(GDM_OFS_UNDER, 8'h3C); // 0.9 V detect
		wr(GDM_OFS_OVER, 8'h64); // 1.5 V detect
		wr(8'h1C, 8'hFF);
		rchk(8'h1C, 8'h00);
		rchk(GDM_OFS_COARSE, 8'h4B);
		`CHK({en, cs}, 9'h000);
		wr(GDM_OFS_FINE, 8'h86); // 5 mV above coarse
		settle();
		`CHK({en, cs, fs}, {1'b1, 8'h4B, 5'h06});
		`CHK({us, os}, 16'h3C64);
		wr(GDM_OFS_FINE, 8'hFF);
		rchk(GDM_OFS_FINE, 8'h9F);
		wr(GDM_OFS_FINE, 8'h1F);
		settle();
		`CHK({en, cs, fs}, 14'h0000);
		wr(GDM_OFS_PE1, 8'h4C);
		rchk(GDM_OFS_PE1, 8'h4C);
		settle();
		`CHK({str, pd, pu}, 3'b111);
		wr(GDM_OFS_PE1, 8'h00);
		settle();
		`CHK({str, pd, pu}, 3'b000);
	endtask

	// Measured gaps carry one extra edge, where the phase is first seen
	task automatic t_dead();
		int h0, l0, h15, l15, h, l, dh, dl;
		dh = ncyc(GDM_HIGH_BASE_NS, 15);
		dl = ncyc(GDM_LOW_BASE_NS, 15);
		wr(GDM_OFS_DEAD, 8'h00);
		cyc2(h0, l0);
		`CHK(h0, ncyc(GDM_HIGH_BASE_NS, 0) + 1);
		`CHK(l0, ncyc(GDM_LOW_BASE_NS, 0) + 1);
		wr(GDM_OFS_DEAD, 8'hFF);
		cyc2(h15, l15);
		`CHK(h15 - h0, dh - ncyc(GDM_HIGH_BASE_NS, 0));
		`CHK(l15 - l0, dl - ncyc(GDM_LOW_BASE_NS, 0));
		wr(GDM_OFS_DEAD, 8'hF0);
		cyc2(h, l);
		`CHK({h, l}, {h15, l0});
		wr(GDM_OFS_DEAD, 8'hFF);
		wr(GDM_OFS_PE1, 8'h30);
		cyc2(h, l);
		`CHK({h15 - h, l15 - l}, {dh - 1, dl - 1});
		wr(GDM_OFS_PE1, 8'h20);
		cyc2(h, l);
		`CHK({h, l}, {h15 - dh + 1, l15});
	endtask

	// Long low phase lets the inductor run dry
	task automatic t_mode();
		int h;
		wr(GDM_OFS_PE1, 8'h80);
		wr(GDM_OFS_DEAD, 8'h00);
		phase(1'b1, 10);
		phase(1'b0, 30);
		`CHK({hi, lo}, 2'b00);
		gap(1'b1, h);
		`CHK(h, ncyc(GDM_HIGH_BASE_NS, 0) + 1);
		`CHK({hi, lo}, 2'b10);
		wr(GDM_OFS_PE1, 8'h00);
		phase(1'b0, 30);
		`CHK({hi, lo}, 2'b01);
	endtask

	task automatic t_flags();
		int h;
		for (int i = 0; i < 2; i++) begin
			@(posedge clock);
			uv <= (i == 0);
			ov <= (i == 1);
			@(posedge clock);
			#1;
			`CHK({uf, of}, 2'b00);
			repeat (5) @(posedge clock);
			uv <= 1'b0;
			ov <= 1'b0;
			repeat (6) @(posedge clock);
			rchk(GDM_OFS_FLAGS, {6'h00, i == 0, i == 1});
			wr(GDM_OFS_FLAGS, 8'h03);
			settle();
			`CHK({uf, of}, 2'b00);
		end
		wr(GDM_OFS_PE1, 8'h03);
		for (int i = 0; i < 2; i++) begin
			gap(1'b1, h);
			@(posedge clock);
			uv <= (i == 0);
			ov <= (i == 1);
			repeat (7) @(posedge clock);
			#1;
			`CHK({hi, lo, pwm}, 3'b001);
			// Clear while the condition persists: the set must win
			wr(GDM_OFS_FLAGS, 8'h03);
			settle();
			`CHK({uf, of}, {i == 0, i == 1});
			@(posedge clock);
			uv <= 1'b0;
			ov <= 1'b0;
			pwm <= 1'b0;
			repeat (8) @(posedge clock);
			wr(GDM_OFS_FLAGS, 8'h03);
		end
	endtask

	initial begin
		bus = '0;
		pwm = 1'b0;
		uv = 1'b0;
		ov = 1'b0;
		arst_n = 1'b0;
		repeat (8) @(posedge clock);
		arst_n <= 1'b1;
		#1;
		t_regs();
		t_dead();
		t_mode();
		t_flags();
		report_and_stop();
	end
endmodule

/* File: verification/gdm_drv_model.sv */
`timescale 1ns/10ps
// Inductor as seen through the two gate drives: current ramps while the
// high side conducts and falls while the low side does.
module gdm_drv_model (
	input  wire logic clock,
	input  wire logic arst_n,
	input  wire logic high_gate_drive,
	input  wire logic low_gate_drive,
	output logic      zero_current_cmp
);
	logic [7:0] amps_q;

	// Current never runs negative, the low switch only drains it
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			amps_q <= 8'h00;
		else if (high_gate_drive)
			amps_q <= amps_q + 8'h01;
		else if (low_gate_drive && amps_q != 8'h00)
			amps_q <= amps_q - 8'h01;
	end

	// Comparator level, high while the inductor is empty
	assign zero_current_cmp = (amps_q == 8'h00);
endmodule
